// ---- iec_capture.sv ----
// iec_capture: input edge capture unit with its own 16-bit timer
// assumes capture_pin is synchronous to hclk; single-slave ahb-lite bus
`timescale 1ns/10ps
module iec_capture #(
	parameter int TW = 16 // timer width
) (
	// clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// ahb-lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// capture pin and timer clock source
	input  wire logic        capture_pin,
	input  wire logic        timer_ext_tick,
	// interrupt request level
	output logic             capture_irq
);
	// refuse timer widths the counter and bus mapping cannot serve
	if (TW != 16) begin : g_bad_tw
		$error("iec_capture: timer width must be 16");
	end

	localparam int     ADDR_W_L = iec_pkg::ADDR_W; // decoded address bits

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	logic [7:0]        ctrl_r, ctrl_nxt;       // control register
	logic              flag_r, flag_nxt;       // capture_irq_flag
	logic              ien_r, ien_nxt;         // capture_irq_enable
	logic [TW-1:0]     timer_r, timer_nxt;     // sixteen_bit_timer
	logic [3:0]        ps_r, ps_nxt;           // edge prescaler
	logic [1:0]        pin_r, pin_nxt;         // pin samples
	logic [3:0]        mode_prev_r;            // mode last cycle
	logic              wr_pend_r, wr_pend_nxt; // data phase write
	logic [ADDR_W_L-1:0] addr_r, addr_nxt;     // latched address
	logic [31:0]       hrdata_r, hrdata_nxt;   // read data
	logic              irq_r, irq_nxt;         // irq output

	logic [3:0]        mode;        // capture_mode_field
	logic              rise, fall;  // detected edges
	logic              event_hit;   // capture event
	logic              spurious;    // mode change glitch
	logic              capture;     // capture strobe
	logic [TW-1:0]     value_rd;    // held capture value
	logic              addr_ok;     // address phase valid
	logic              tick;        // timer increment

	assign mode = ctrl_r[iec_pkg::MODE_LSB +: iec_pkg::MODE_W];

	// decode of mode into capture mode check
	function automatic logic is_capture(input logic [3:0] m);
		is_capture = (m == iec_pkg::MODE_FALL) ||
			(m == iec_pkg::MODE_RISE) ||
			(m == iec_pkg::MODE_RISE4) ||
			(m == iec_pkg::MODE_RISE16);
	endfunction : is_capture

	// ----------------------------------------------------------------
	// edge detection
	// ----------------------------------------------------------------
	always_comb begin
		pin_nxt = {pin_r[0], capture_pin};
		rise = pin_r[0] & ~pin_r[1];
		fall = ~pin_r[0] & pin_r[1];
	end

	// prescaler and event selection
	always_comb begin
		ps_nxt = ps_r;
		event_hit = 1'b0;
		unique case (mode)
			iec_pkg::MODE_FALL: event_hit = fall;
			iec_pkg::MODE_RISE: event_hit = rise;
			iec_pkg::MODE_RISE4: begin
				if (rise) begin
					ps_nxt = (ps_r >= iec_pkg::PS_MAX4) ? 4'h0 : ps_r + 4'h1;
					event_hit = (ps_r >= iec_pkg::PS_MAX4);
				end
			end
			iec_pkg::MODE_RISE16: begin
				if (rise) begin
					ps_nxt = ps_r + 4'h1;
					event_hit = (ps_r == iec_pkg::PS_MAX16);
				end
			end
			default: ps_nxt = 4'h0;
		endcase
		// cleared when off or not capturing
		if (!is_capture(mode)) begin
			ps_nxt = 4'h0;
		end
		spurious = is_capture(mode) && (mode != mode_prev_r);
		capture = event_hit | spurious;
	end

	// ----------------------------------------------------------------
	// timer
	// ----------------------------------------------------------------
	always_comb begin
		// timer from hclk or external tick
		tick = ctrl_r[iec_pkg::TIMER_EXT_BIT] ? timer_ext_tick : 1'b1;
		timer_nxt = timer_r;
		if (ctrl_r[iec_pkg::TIMER_RUN_BIT] && tick) begin
			timer_nxt = timer_r + 16'h0001;
		end
	end

	// held capture value
	iec_capture_mem #(
		.WIDTH(TW)
	) u_mem (
		.hclk    (hclk),
		.hresetn (hresetn),
		.wr_en   (capture),
		.wr_data (timer_r),
		.rd_data (value_rd)
	);

	// ----------------------------------------------------------------
	// bus slave
	// ----------------------------------------------------------------
	assign addr_ok = hsel && hready && (htrans == iec_pkg::HTRANS_NONSEQ);

	always_comb begin
		ctrl_nxt    = ctrl_r;
		ien_nxt     = ien_r;
		flag_nxt    = flag_r;
		wr_pend_nxt = 1'b0;
		addr_nxt    = addr_r;
		hrdata_nxt  = hrdata_r;
		if (addr_ok) begin
			addr_nxt    = haddr[ADDR_W_L-1:0];
			wr_pend_nxt = hwrite;
			// read data registered at address phase
			unique case (haddr[ADDR_W_L-1:0])
				iec_pkg::CTRL_OFS:   hrdata_nxt = {24'h000000, ctrl_r};
				iec_pkg::VALUE_OFS:  hrdata_nxt = {16'h0000, value_rd};
				iec_pkg::FLAG_OFS:   hrdata_nxt = {31'h00000000, flag_r};
				iec_pkg::ENABLE_OFS: hrdata_nxt = {31'h00000000, ien_r};
				iec_pkg::TIMER_OFS:  hrdata_nxt = {16'h0000, timer_r};
				default:             hrdata_nxt = 32'h00000000;
			endcase
		end
		// write data phase
		if (wr_pend_r) begin
			unique case (addr_r)
				iec_pkg::CTRL_OFS:   ctrl_nxt = hwdata[7:0];
				iec_pkg::FLAG_OFS:   flag_nxt = hwdata[iec_pkg::FLAG_BIT];
				iec_pkg::ENABLE_OFS: ien_nxt = hwdata[iec_pkg::FLAG_BIT];
				default:             ctrl_nxt = ctrl_r;
			endcase
		end
		if (capture) begin
			flag_nxt = 1'b1;
		end
		irq_nxt = flag_nxt & ien_nxt;
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_r      <= iec_pkg::CTRL_RST;
			flag_r      <= 1'b0;
			ien_r       <= 1'b0;
			timer_r     <= '0;
			ps_r        <= 4'h0;
			pin_r       <= 2'h0;
			mode_prev_r <= iec_pkg::MODE_OFF;
			wr_pend_r   <= 1'b0;
			addr_r      <= '0;
			hrdata_r    <= 32'h00000000;
			irq_r       <= 1'b0;
		end else begin
			ctrl_r      <= ctrl_nxt;
			flag_r      <= flag_nxt;
			ien_r       <= ien_nxt;
			timer_r     <= timer_nxt;
			ps_r        <= ps_nxt;
			pin_r       <= pin_nxt;
			mode_prev_r <= mode;
			wr_pend_r   <= wr_pend_nxt;
			addr_r      <= addr_nxt;
			hrdata_r    <= hrdata_nxt;
			irq_r       <= irq_nxt;
		end
	end

	assign hrdata      = hrdata_r;
	assign hreadyout   = 1'b1;
	assign hresp       = 1'b0;
	assign capture_irq = irq_r;
endmodule : iec_capture

// ---- iec_capture_asserts.sv ----
// iec_capture_asserts: port-level checks on iec_capture
// assumes one ahb-lite slave with zero wait states
`timescale 1ns/10ps
module iec_capture_asserts (
	// clock and reset
	input wire logic        hclk,
	input wire logic        hresetn,
	// bus
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic [31:0] hwdata,
	input wire logic        hready,
	input wire logic [31:0] hrdata,
	input wire logic        hreadyout,
	input wire logic        hresp,
	// pin and irq
	input wire logic        capture_pin,
	input wire logic        capture_irq
);
	logic       act_r; // data phase pending
	logic       wr_r;  // data phase is a write
	logic [7:0] adr_r; // data phase address
	logic [3:0] mode_r; // mirrored mode field
	logic       en_r;  // mirrored irq enable
	// follow address and data phases
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			act_r  <= 1'b0;
			wr_r   <= 1'b0;
			adr_r  <= 8'h00;
			mode_r <= 4'h0;
			en_r   <= 1'b0;
		end else begin
			act_r <= hsel && hready && htrans == iec_pkg::HTRANS_NONSEQ;
			wr_r  <= hsel && hready && htrans == iec_pkg::HTRANS_NONSEQ && hwrite;
			adr_r <= haddr[7:0];
			if (wr_r && adr_r == iec_pkg::CTRL_OFS) begin
				mode_r <= hwdata[3:0];
			end
			if (wr_r && adr_r == iec_pkg::ENABLE_OFS) begin
				en_r <= hwdata[0];
			end
		end
	end
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);
	chk_zero_wait: assert property (hreadyout)
		else $error("wait state inserted");
	chk_resp_okay: assert property (!hresp)
		else $error("error response");
	chk_reset_state: assert property ($rose(hresetn) |-> hrdata == 32'h0 &&
		!capture_irq) else $error("outputs not cleared by reset");
	chk_unmapped_zero: assert property (act_r && !wr_r && adr_r > 8'h13 |->
		hrdata == 32'h0) else $error("unmapped read not zero");
	chk_value_upper: assert property (act_r && !wr_r &&
		adr_r == iec_pkg::VALUE_OFS |-> hrdata[31:16] == 16'h0)
		else $error("value upper half not zero");
	chk_irq_holds: assert property (capture_irq && !wr_r && !$past(wr_r) |=>
		capture_irq) else $error("irq dropped without a write");
	chk_rise_capture: assert property (en_r && mode_r == iec_pkg::MODE_RISE &&
		$rose(capture_pin) |-> ##[1:6] capture_irq) else $error("rise missed");
	chk_fall_capture: assert property (en_r && mode_r == iec_pkg::MODE_FALL &&
		$fell(capture_pin) |-> ##[1:6] capture_irq) else $error("fall missed");
endmodule : iec_capture_asserts

// ---- iec_capture_mem.sv ----
// iec_capture_mem: single holding register for the captured count
// assumes write strobe is a single-cycle pulse on hclk
`timescale 1ns/10ps
module iec_capture_mem #(
	parameter int WIDTH = 16
) (
	// clock and reset
	input  wire logic             hclk,
	input  wire logic             hresetn,
	// write side
	input  wire logic             wr_en,
	input  wire logic [WIDTH-1:0] wr_data,
	// read side
	output logic      [WIDTH-1:0] rd_data
);
	logic [WIDTH-1:0] value_r;   // held capture
	logic [WIDTH-1:0] value_nxt; // next held capture

	// ----------------------------------------------------------------
	// next value
	// ----------------------------------------------------------------
	always_comb begin
		value_nxt = value_r;
		if (wr_en) begin
			value_nxt = wr_data;
		end
	end

	// register
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			value_r <= '0;
		end else begin
			value_r <= value_nxt;
		end
	end

	assign rd_data = value_r;
endmodule : iec_capture_mem

// ---- iec_capture_test.sv ----
// iec_capture_test: self-checking bench for iec_capture
// assumes iec_pin_model drives the pin; tasks here master the bus
`timescale 1ns/10ps
module iec_capture_test;
	logic        hclk, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
	logic [1:0]  htrans = 2'h0;
	logic [2:0]  hsize = iec_pkg::HSIZE_WORD;
	logic        hready, hreadyout, hresp, capture_pin, capture_irq;
	logic        timer_ext_tick = 1'b0;
	logic [15:0] exp_t = 16'h0; // expected timer count
	int          n_fail = 0, samples_checked = 0, cyc = 0;
	assign hready = hreadyout;
	iec_capture DUT (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
		.hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp,
		.capture_pin, .timer_ext_tick, .capture_irq);
	iec_pin_model pm (.hclk, .capture_pin);
	initial begin
		hclk = 1'b0;
		forever #5 hclk = ~hclk;
	end
	// ----
	// bus, compare and verdict
	// ----
	task automatic ahb(input logic [7:0] a, input logic w, input logic [31:0] d);
		@(posedge hclk);
		hsel   <= 1'b1;
		haddr  <= {24'h0, a};
		hwrite <= w;
		htrans <= iec_pkg::HTRANS_NONSEQ;
		do @(posedge hclk); while (hready !== 1'b1);
		hsel   <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hready !== 1'b1);
		rd = hrdata;
	endtask : ahb
	task automatic check(input logic [31:0] s, input logic [31:0] e);
		samples_checked++;
		if (s !== e) begin
			n_fail++;
			$display("unexpected at %0t: %h vs %h", $time, s, e);
		end
	endtask : check
	task automatic print_verdict;
		if (n_fail == 0 && samples_checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : print_verdict
	task automatic wait_n(input int n);
		repeat (n) @(posedge hclk);
		#1;
	endtask : wait_n
	// timer advanced by external ticks only
	task automatic ticks(input int k);
		repeat (k) begin
			@(posedge hclk);
			timer_ext_tick <= 1'b1;
			@(posedge hclk);
			timer_ext_tick <= 1'b0;
		end
		exp_t = exp_t + k[15:0];
	endtask : ticks
	// ----
	// scenarios
	// ----
	task automatic s_reset_regs;
		logic [7:0] a [7] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h40};
		ahb(8'h40, 1'b1, 32'hffffffff);
		foreach (a[i]) begin
			ahb(a[i], 1'b0, 32'h0);
			check(rd, 32'h0);
		end
	endtask : s_reset_regs
	task automatic s_modes;
		logic [3:0] m [4] = '{iec_pkg::MODE_FALL, iec_pkg::MODE_RISE,
			iec_pkg::MODE_RISE4, iec_pkg::MODE_RISE16};
		int c [4] = '{1, 1, 4, 16};
		for (int i = 0; i < 4; i++) begin
			// off between prescalers, then clear flag
			ahb(iec_pkg::CTRL_OFS, 1'b1, 32'h30);
			ahb(iec_pkg::CTRL_OFS, 1'b1, {24'h0, 4'h3, m[i]});
			ahb(iec_pkg::FLAG_OFS, 1'b1, 32'h0);
			for (int k = 0; k < 2; k++) begin
				ticks(3 + i + k);
				pm.pulses(c[i] - 1, 2 + 3 * k);
				wait_n(6);
				ahb(iec_pkg::FLAG_OFS, 1'b0, 32'h0);
				check({31'h0, rd[0]}, {31'h0, k[0]});
				pm.pulses(1, 2 + 3 * k);
				wait_n(6);
				ahb(iec_pkg::FLAG_OFS, 1'b0, 32'h0);
				check({31'h0, rd[0]}, 32'h1);
				ahb(iec_pkg::VALUE_OFS, 1'b0, 32'h0);
				check(rd, {16'h0, exp_t});
			end
		end
		ahb(iec_pkg::TIMER_OFS, 1'b0, 32'h0);
		check(rd, {16'h0, exp_t});
	endtask : s_modes
	task automatic s_irq;
		logic [3:0] m [2] = '{iec_pkg::MODE_FALL, iec_pkg::MODE_RISE};
		for (int i = 0; i < 2; i++) begin
			ahb(iec_pkg::CTRL_OFS, 1'b1, 32'h30);
			ahb(iec_pkg::CTRL_OFS, 1'b1, {24'h0, 4'h3, m[i]});
			ahb(iec_pkg::FLAG_OFS, 1'b1, 32'h0);
			ahb(iec_pkg::ENABLE_OFS, 1'b1, 32'h1);
			wait_n(2);
			check({31'h0, capture_irq}, 32'h0);
			pm.pulses(1, 3);
			wait_n(6);
			check({31'h0, capture_irq}, 32'h1);
			ahb(iec_pkg::ENABLE_OFS, 1'b1, 32'h0);
			wait_n(2);
			check({31'h0, capture_irq}, 32'h0);
			ahb(iec_pkg::ENABLE_OFS, 1'b1, 32'h1);
			wait_n(2);
			check({31'h0, capture_irq}, 32'h1);
			ahb(iec_pkg::FLAG_OFS, 1'b1, 32'h0);
			wait_n(2);
			check({31'h0, capture_irq}, 32'h0);
			ahb(iec_pkg::ENABLE_OFS, 1'b1, 32'h0);
		end
	endtask : s_irq
	// cut a hang short
	always @(posedge hclk) begin
		cyc++;
		if (cyc == 20000) begin
			n_fail++;
			print_verdict();
		end
	end
	initial begin
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		s_reset_regs();
		s_modes();
		s_irq();
		print_verdict();
	end
endmodule : iec_capture_test
bind iec_capture iec_capture_asserts chk (.hclk, .hresetn, .hsel, .haddr,
	.htrans, .hwrite, .hwdata, .hready, .hrdata, .hreadyout, .hresp,
	.capture_pin, .capture_irq);

// ---- iec_pin_model.sv ----
// iec_pin_model: external signal source on capture_pin
// assumes levels change just after hclk edges, idle low
`timescale 1ns/10ps
module iec_pin_model (
	// clock
	input wire logic hclk,
	// pin
	output logic     capture_pin
);
	initial capture_pin = 1'b0;
	// pin driven from outside
	// n pulses, each w cycles high then w low
	task automatic pulses(input int n, input int w);
		repeat (n) begin
			@(posedge hclk);
			capture_pin <= 1'b1;
			repeat (w) @(posedge hclk);
			capture_pin <= 1'b0;
			repeat (w) @(posedge hclk);
		end
	endtask : pulses
endmodule : iec_pin_model

// ---- iec_pkg.sv ----
// iec_pkg: constants for the input edge capture block
// assumes a 32-bit ahb-lite slave with word-aligned registers
package iec_pkg;
	// ----------------------------------------------------------------
	// register byte offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] CTRL_OFS   = 8'h00; // capture_control_register
	localparam logic [7:0] VALUE_OFS  = 8'h04; // capture_value_high:low
	localparam logic [7:0] FLAG_OFS   = 8'h08; // peripheral_flag_register
	localparam logic [7:0] ENABLE_OFS = 8'h0c; // peripheral_enable_register
	localparam logic [7:0] TIMER_OFS  = 8'h10; // sixteen_bit_timer
	localparam int         ADDR_W     = 8;
	// ----------------------------------------------------------------
	// capture_mode_field codes
	// ----------------------------------------------------------------
	localparam logic [3:0] MODE_OFF   = 4'h0;
	localparam logic [3:0] MODE_FALL  = 4'h4;
	localparam logic [3:0] MODE_RISE  = 4'h5;
	localparam logic [3:0] MODE_RISE4 = 4'h6;
	localparam logic [3:0] MODE_RISE16 = 4'h7;
	// ----------------------------------------------------------------
	// field positions and reset values
	// ----------------------------------------------------------------
	localparam int         MODE_LSB   = 0;
	localparam int         MODE_W     = 4;
	localparam int         FLAG_BIT   = 0;
	localparam int         TIMER_RUN_BIT = 4;
	localparam int         TIMER_EXT_BIT = 5;
	localparam logic [7:0] CTRL_RST   = 8'h00;
	localparam logic [3:0] PS_MAX4    = 4'h3;
	localparam logic [3:0] PS_MAX16   = 4'hf;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [2:0] HSIZE_WORD = 3'h2;
endpackage : iec_pkg
